// >>> hw/psep_port_top.sv
// Pin logic for a six-pin bidirectional port and two input-only ports.
// Assumes the bus controller pulses i_bus_first_state in the first bus state,
// and that the access port and bus signals are on the core clock.
module psep_port_top #(
  parameter int BIDIR_W = psep_pkg::BIDIR_W,
  parameter int IN8_W = psep_pkg::IN8_W,
  parameter int IN4_W = psep_pkg::IN4_W
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_acc_wr,
  input wire logic i_acc_rd,
  input wire logic [1:0] i_acc_sel,
  input wire logic [psep_pkg::BYTE_W-1:0] i_acc_wdata,
  output logic [psep_pkg::BYTE_W-1:0] o_acc_rdata,
  output logic o_acc_rvalid,
  input wire logic [BIDIR_W-1:0] i_bidir_port_direction_reg,
  input wire logic i_memory_expansion_select_reg,
  input wire logic i_bus_first_state,
  input wire logic [psep_pkg::ADDR_W-1:0] i_bus_addr,
  input wire logic [BIDIR_W-1:0] i_bidir_port_pins,
  output logic [BIDIR_W-1:0] o_bidir_port_pins,
  output logic [BIDIR_W-1:0] o_bidir_port_pins_oe_n,
  input wire logic [IN8_W-1:0] i_input_port_eight_pins,
  input wire logic [IN4_W-1:0] i_input_port_four_pins,
  output logic [IN8_W+IN4_W-1:0] o_analog_channel_inputs
);
  // The widths are fixed by the pin map; other values cannot fit the byte path
  // or the address slice.
  if (BIDIR_W != psep_pkg::BIDIR_W || IN8_W != psep_pkg::IN8_W || IN4_W != psep_pkg::IN4_W) begin : g_chk
    $error("psep_port_top: port widths must match the pin map");
  end

  // Pin synchronisers
  // Every pin level crosses two flops before any read, so reads and the analog
  // copies trail a pin change by three edges; software never sees a settling level.
  psep_sync_if #(.W(BIDIR_W)) bidir_sif ();
  psep_sync_if #(.W(IN8_W)) in8_sif ();
  psep_sync_if #(.W(IN4_W)) in4_sif ();

  assign bidir_sif.raw = i_bidir_port_pins;
  assign in8_sif.raw = i_input_port_eight_pins;
  assign in4_sif.raw = i_input_port_four_pins;

  psep_pin_sync #(.W(BIDIR_W)) u_sync_bidir (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .sif(bidir_sif.sync_side)
  );

  psep_pin_sync #(.W(IN8_W)) u_sync_in8 (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .sif(in8_sif.sync_side)
  );

  psep_pin_sync #(.W(IN4_W)) u_sync_in4 (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .sif(in4_sif.sync_side)
  );

  // Widen a narrow value to a byte with zeros above it
  // Shared by both six-pin read branches
  function automatic logic [psep_pkg::BYTE_W-1:0] zext_bidir(input logic [BIDIR_W-1:0] v);
    logic [psep_pkg::BYTE_W-1:0] r;
    r = '0;
    r[BIDIR_W-1:0] = v;
    return r;
  endfunction : zext_bidir

  // Mixed read of the six-pin port: output bits show the latch, input bits the pin
  function automatic logic [BIDIR_W-1:0] bidir_view(
    input logic [BIDIR_W-1:0] dir,
    input logic [BIDIR_W-1:0] latch,
    input logic [BIDIR_W-1:0] pins
  );
    return (dir & pins) | (~dir & latch);
  endfunction : bidir_view

  // Port state
  // Direction and select are taken as levels; pins follow them one edge later.
  logic [BIDIR_W-1:0] dir_r;
  logic [BIDIR_W-1:0] dir_nxt;
  logic exp_mode_r;
  logic exp_mode_nxt;
  logic [BIDIR_W-1:0] latch_r;
  logic [BIDIR_W-1:0] latch_nxt;
  logic [BIDIR_W-1:0] addr_hold_r;
  logic [BIDIR_W-1:0] addr_hold_nxt;
  logic [BIDIR_W-1:0] pin_out_r;
  logic [BIDIR_W-1:0] pin_out_nxt;
  logic [BIDIR_W-1:0] pin_oe_n_r;
  logic [BIDIR_W-1:0] pin_oe_n_nxt;
  logic [BIDIR_W-1:0] bus_addr_hi;

  assign bus_addr_hi = i_bus_addr[psep_pkg::ADDR_HI_LSB +: BIDIR_W];

  always_comb begin
    dir_nxt = i_bidir_port_direction_reg;
    exp_mode_nxt = i_memory_expansion_select_reg;
    latch_nxt = latch_r;
    // Only the low six bits of a byte write reach the latch
    if (i_acc_wr && i_acc_sel == psep_pkg::SEL_BIDIR) begin
      latch_nxt = i_acc_wdata[BIDIR_W-1:0];
    end
    // Captured at the first-state edge, otherwise held between cycles
    // Capture runs in both modes, so a held address is ready the moment
    // address mode is chosen; the cost is a register that toggles unused.
    addr_hold_nxt = addr_hold_r;
    if (i_bus_first_state) begin
      addr_hold_nxt = bus_addr_hi;
    end
    if (i_memory_expansion_select_reg) begin
      // Address mode overrides direction bits: all six pins drive
      pin_out_nxt = addr_hold_nxt;
      pin_oe_n_nxt = '0;
    end else begin
      pin_out_nxt = latch_nxt;
      pin_oe_n_nxt = i_bidir_port_direction_reg;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      dir_r <= psep_pkg::DIR_RST;
      exp_mode_r <= 1'b0;
      latch_r <= psep_pkg::LATCH_RST;
      addr_hold_r <= psep_pkg::ADDR_HI_RST;
      pin_out_r <= psep_pkg::LATCH_RST;
      pin_oe_n_r <= psep_pkg::DIR_RST;
    end else begin
      dir_r <= dir_nxt;
      exp_mode_r <= exp_mode_nxt;
      latch_r <= latch_nxt;
      addr_hold_r <= addr_hold_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_n_r <= pin_oe_n_nxt;
    end
  end

  assign o_bidir_port_pins = pin_out_r;
  assign o_bidir_port_pins_oe_n = pin_oe_n_r;

  // Read path
  // A read in the same cycle as a write sees the old latch; the new value
  // shows from the next read on.
  logic [psep_pkg::BYTE_W-1:0] rdata_r;
  logic [psep_pkg::BYTE_W-1:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;

  always_comb begin
    rvalid_nxt = i_acc_rd;
    rdata_nxt = rdata_r;
    if (i_acc_rd) begin
      case (i_acc_sel)
        psep_pkg::SEL_BIDIR: begin
          // In address mode every pin is an output, so the pins read back
          if (exp_mode_r) begin
            rdata_nxt = zext_bidir(bidir_sif.sync);
          end else begin
            rdata_nxt = zext_bidir(bidir_view(dir_r, latch_r, bidir_sif.sync));
          end
        end
        psep_pkg::SEL_IN8: begin
          rdata_nxt = in8_sif.sync;
        end
        psep_pkg::SEL_IN4: begin
          rdata_nxt = {{(psep_pkg::BYTE_W-IN4_W){1'b0}}, in4_sif.sync};
        end
        default: begin
          rdata_nxt = psep_pkg::RDATA_RST;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rdata_r <= psep_pkg::RDATA_RST;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign o_acc_rdata = rdata_r;
  assign o_acc_rvalid = rvalid_r;

  // Input-only pins have no output stage; writes to them are dropped
  // and they feed the converter channels with no gating.
  // Registering the copies keeps the converter side off the synchroniser nets.
  logic [IN8_W+IN4_W-1:0] analog_r;
  logic [IN8_W+IN4_W-1:0] analog_nxt;

  always_comb begin
    analog_nxt = {in4_sif.sync, in8_sif.sync};
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      analog_r <= psep_pkg::ANALOG_RST;
    end else begin
      analog_r <= analog_nxt;
    end
  end

  assign o_analog_channel_inputs = analog_r;
endmodule : psep_port_top

// >>> hw/psep_pkg.sv
// Constants shared by the six/eight/four pin port logic.
// Assumes one core clock and a synchronous active-high reset.
package psep_pkg;
  localparam int BIDIR_W = 6;
  localparam int IN8_W = 8;
  localparam int IN4_W = 4;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 22;
  localparam int ADDR_HI_LSB = 16;
  localparam int ANALOG_W = IN8_W + IN4_W;
  localparam int SYNC_STAGES = 2;
  // Port select codes on the access port
  localparam logic [1:0] SEL_BIDIR = 2'h0;
  localparam logic [1:0] SEL_IN8 = 2'h1;
  localparam logic [1:0] SEL_IN4 = 2'h2;
  // Direction bit: 1 = input, 0 = output
  localparam logic [BIDIR_W-1:0] DIR_RST = 6'h3F;
  localparam logic [BIDIR_W-1:0] LATCH_RST = 6'h00;
  localparam logic [BIDIR_W-1:0] ADDR_HI_RST = 6'h00;
  localparam logic [BYTE_W-1:0] RDATA_RST = 8'h00;
  localparam logic [ANALOG_W-1:0] ANALOG_RST = 12'h000;
endpackage : psep_pkg

// >>> hw/psep_sync_if.sv
// Carries raw pin levels into the synchroniser and the clean levels back.
// Assumes both ends sit on the core clock.
interface psep_sync_if #(
  parameter int W = 1
);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport sync_side (input raw, output sync);
  modport user (output raw, input sync);
endinterface : psep_sync_if

// >>> hw/psep_pin_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes the raw levels may change at any time relative to the clock.
module psep_pin_sync #(
  parameter int W = 1
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  psep_sync_if.sync_side sif
);
  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;
  logic [W-1:0] stage1_nxt;
  logic [W-1:0] stage2_nxt;

  if (W < 1) begin : g_chk
    $error("psep_pin_sync: width must be at least one");
  end

  always_comb begin
    stage1_nxt = sif.raw;
    // First stage feeds only the second stage
    stage2_nxt = stage1_r;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= stage1_nxt;
      stage2_r <= stage2_nxt;
    end
  end

  assign sif.sync = stage2_r;
endmodule : psep_pin_sync

// >>> testbench/psep_sva.sv
// Checker for the six/eight/four pin port block, bound to its top module.
// Assumes input pins are held steady for some cycles before they are read.
module psep_sva (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_acc_rd,
  input wire logic [1:0] i_acc_sel,
  input wire logic [7:0] o_acc_rdata,
  input wire logic o_acc_rvalid,
  input wire logic [5:0] i_bidir_port_direction_reg,
  input wire logic i_memory_expansion_select_reg,
  input wire logic i_bus_first_state,
  input wire logic [21:0] i_bus_addr,
  input wire logic [5:0] o_bidir_port_pins,
  input wire logic [5:0] o_bidir_port_pins_oe_n,
  input wire logic [7:0] i_input_port_eight_pins,
  input wire logic [3:0] i_input_port_four_pins,
  input wire logic [11:0] o_analog_channel_inputs
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  wire logic mx = i_memory_expansion_select_reg;
  wire logic rd = i_acc_rd;
  wire logic [11:0] in_now = {i_input_port_four_pins, i_input_port_eight_pins};
  logic [2:0] st_r;
  logic [2:0] st_nxt;
  logic [11:0] in_r;
  // Counts edges the input pins have held still, so sync latency is covered
  always_comb st_nxt = (i_reset || in_now != in_r) ? 3'h0 : (st_r == 3'h7 ? st_r : st_r + 3'h1);
  always_ff @(posedge i_core_clk) begin
    st_r <= st_nxt;
    in_r <= in_now;
  end
  chk_addr_drive: assert property (
    i_bus_first_state && mx && $past(mx) |=> o_bidir_port_pins == $past(i_bus_addr[21:16])
    && o_bidir_port_pins_oe_n == 6'h00) else $error("address not driven");
  chk_addr_hold: assert property (
    !i_bus_first_state && mx && $past(mx) |=> $stable(o_bidir_port_pins)) else $error("address moved");
  chk_dir_oe: assert property (
    !$past(mx) |-> o_bidir_port_pins_oe_n == $past(i_bidir_port_direction_reg)) else $error("bad enable");
  chk_rd_valid: assert property (rd |=> o_acc_rvalid) else $error("no read valid");
  chk_valid_cause: assert property (o_acc_rvalid |-> $past(rd)) else $error("stray valid");
  chk_rd_six: assert property (
    rd && i_acc_sel == 2'h0 |=> o_acc_rdata[7:6] == 2'h0) else $error("top bits set");
  chk_rd_eight: assert property (
    rd && i_acc_sel == 2'h1 && st_r > 3'h3 |=> o_acc_rdata == $past(i_input_port_eight_pins, 3))
    else $error("bad eight pin read");
  chk_rd_four: assert property (
    rd && i_acc_sel == 2'h2 && st_r > 3'h3 |=> o_acc_rdata == {4'h0, $past(i_input_port_four_pins, 3)})
    else $error("bad four pin read");
  chk_rd_none: assert property (rd && i_acc_sel == 2'h3 |=> o_acc_rdata == 8'h00) else $error("unmapped");
  chk_analog_copy: assert property (
    st_r > 3'h4 |-> o_analog_channel_inputs == $past(in_now, 3)) else $error("analog copy wrong");
endmodule : psep_sva

// >>> testbench/psep_board.sv
// Board model for the six bidirectional pins.
// Assumes the block drives a pin only while its enable is low.
module psep_board (
  input wire logic [5:0] i_board_drive,
  input wire logic [5:0] i_pin_out,
  input wire logic [5:0] i_pin_oe_n,
  output logic [5:0] o_pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Board drives only released pins, so no contention is modelled
  assign o_pin_level = (i_pin_oe_n & i_board_drive) | (~i_pin_oe_n & i_pin_out);
endmodule : psep_board

// >>> testbench/tb.sv
// Self-checking bench for the six/eight/four pin port block.
// Assumes the board model resolves the bidirectional pin levels.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic fs = 1'b0;
  logic mx = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic [5:0] dir = 6'h3F;
  logic [21:0] addr = 22'h00_0000;
  logic [5:0] ext = 6'h15;
  logic [7:0] in8 = 8'h00;
  logic [3:0] in4 = 4'h0;
  logic [7:0] rdata;
  logic rvalid;
  logic [5:0] lvl;
  logic [5:0] pout;
  logic [5:0] oen;
  logic [11:0] ana;
  int n_mismatch = 0;
  int checks_done = 0;
  always #5 i_core_clk = ~i_core_clk;
  psep_port_top dut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_acc_wr(wr), .i_acc_rd(rd),
    .i_acc_sel(sel), .i_acc_wdata(wdata), .o_acc_rdata(rdata), .o_acc_rvalid(rvalid),
    .i_bidir_port_direction_reg(dir), .i_memory_expansion_select_reg(mx), .i_bus_first_state(fs),
    .i_bus_addr(addr), .i_bidir_port_pins(lvl), .o_bidir_port_pins(pout), .o_bidir_port_pins_oe_n(oen),
    .i_input_port_eight_pins(in8), .i_input_port_four_pins(in4), .o_analog_channel_inputs(ana));
  psep_board board (.i_board_drive(ext), .i_pin_out(pout), .i_pin_oe_n(oen), .o_pin_level(lvl));
  task automatic rd_chk(input logic [1:0] s, input logic [7:0] exp);
    @(negedge i_core_clk);
    rd = 1'b1;
    sel = s;
    @(negedge i_core_clk);
    rd = 1'b0;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, exp)
  endtask : rd_chk
  task automatic wr_do(input logic [1:0] s, input logic [7:0] d);
    @(negedge i_core_clk);
    wr = 1'b1;
    sel = s;
    wdata = d;
    @(negedge i_core_clk);
    wr = 1'b0;
  endtask : wr_do
  task automatic t_inputs();
    in8 = 8'hA5;
    in4 = 4'hC;
    repeat (6) @(negedge i_core_clk);
    `CHK(ana, 12'hCA5)
    rd_chk(2'h1, 8'hA5);
    rd_chk(2'h2, 8'h0C);
    wr_do(2'h1, 8'h00);
    rd_chk(2'h1, 8'hA5);
    rd_chk(2'h3, 8'h00);
  endtask : t_inputs
  task automatic t_bidir();
    dir = 6'h30;
    wr_do(2'h0, 8'hEA);
    @(negedge i_core_clk);
    `CHK(oen, 6'h30)
    `CHK(pout[3:0], 4'hA)
    rd_chk(2'h0, 8'h1A);
    dir = 6'h0F;
    repeat (2) @(negedge i_core_clk);
    `CHK(oen, 6'h0F)
    `CHK(pout[5:4], 2'h2)
  endtask : t_bidir
  task automatic t_addr();
    mx = 1'b1;
    @(negedge i_core_clk);
    fs = 1'b1;
    addr = 22'h2A_5555;
    @(negedge i_core_clk);
    fs = 1'b0;
    `CHK(pout, 6'h2A)
    `CHK(oen, 6'h00)
    addr = 22'h15_0000;
    repeat (3) @(negedge i_core_clk);
    `CHK(pout, 6'h2A)
    fs = 1'b1;
    @(negedge i_core_clk);
    addr = 22'h3F_FFFF;
    @(negedge i_core_clk);
    fs = 1'b0;
    `CHK(pout, 6'h3F)
    // Driven address must pass the pin sync before it reads back
    @(negedge i_core_clk);
    rd_chk(2'h0, 8'h3F);
    mx = 1'b0;
    repeat (2) @(negedge i_core_clk);
    `CHK(oen, 6'h0F)
  endtask : t_addr
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (12) @(negedge i_core_clk);
    i_reset = 1'b0;
    `CHK(oen, 6'h3F)
    t_inputs();
    t_bidir();
    t_addr();
    final_report();
  end
  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end
endmodule : tb
bind psep_port_top psep_sva chk (
  .i_core_clk(i_core_clk),
  .i_reset(i_reset),
  .i_acc_rd(i_acc_rd),
  .i_acc_sel(i_acc_sel),
  .o_acc_rdata(o_acc_rdata),
  .o_acc_rvalid(o_acc_rvalid),
  .i_bidir_port_direction_reg(i_bidir_port_direction_reg),
  .i_memory_expansion_select_reg(i_memory_expansion_select_reg),
  .i_bus_first_state(i_bus_first_state),
  .i_bus_addr(i_bus_addr),
  .o_bidir_port_pins(o_bidir_port_pins),
  .o_bidir_port_pins_oe_n(o_bidir_port_pins_oe_n),
  .i_input_port_eight_pins(i_input_port_eight_pins),
  .i_input_port_four_pins(i_input_port_four_pins),
  .o_analog_channel_inputs(o_analog_channel_inputs)
);
